// file: hw/epp_consts.svh
// Constants for the parallel port cycle engine
`ifndef EPP_CONSTS_SVH
`define EPP_CONSTS_SVH
`define EPP_CLK_MHZ 125
`define EPP_TIMEOUT_NS 10000
`define EPP_TIMEOUT_CYC ((`EPP_TIMEOUT_NS * `EPP_CLK_MHZ) / 1000)
`define EPP_REG_CTRL 4'h0
`define EPP_REG_STATUS 4'h1
`define EPP_REG_DATA 4'h2
`define EPP_REG_ADDR 4'h3
`define EPP_REG_LAST 4'h4
`define EPP_CTRL_DIR_BIT 5
`define EPP_CTRL_NWRITE_BIT 1
`define EPP_CTRL_RESET_BIT 2
`define EPP_STAT_TIMEOUT_BIT 0
`define EPP_STAT_INTR_BIT 1
`define EPP_STAT_BUSY_BIT 2
`define EPP_CTRL_RESET_VAL 8'h04
`endif

// file: hw/epp_pkg.sv
// Types for the parallel port cycle engine
package epp_pkg;
    typedef enum logic [2:0] {
        EPP_IDLE,
        EPP_STROBE,
        EPP_HOLD,
        EPP_ABORT
    } epp_state_t;
endpackage : epp_pkg

// file: hw/epp_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module epp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : epp_sync

// file: hw/epp_cycle_engine.sv
// EPP 1.7 cycle engine between a host register port and a parallel port
// Function
// RULE1: Software clears the direction bit before a write, asserting nwrite.
// RULE2: A host write to a port register drives the byte onto the port bus.
// RULE3: During a write, a strobe asserts once port data and nwrite are valid.
// RULE4: Ready is held low while wait is asserted, released on wait or timeout.
// RULE5: Ending host write drops the strobe and latches the host byte.
// RULE6: Software sets the direction bit before a read, floating the port bus.
// RULE7: A host read asserts a strobe with bus floated, direction high.
// RULE8: Peripheral drives read data then deasserts wait.
// RULE9: Ending host read drops the active strobe.
// RULE10: Peripheral floats the port bus after the read strobe ends.
// RULE11: After a cycle nwrite, direction and drive enable may change.
// RULE12: A cycle completes only once wait is high; low wait stretches it.
// RULE13: Peripheral drives wait high to acknowledge, low when ready.
// RULE14: Interrupt input is active high, rising-edge, passed uninverted.
// RULE15: An active-low reset output returns the peripheral to initial mode.
// RULE16: Direction output low for write, high for read.
// RULE17: Direction output low by default, high on direction bit or read.
// RULE18: During a cycle only nwrite may be overridden by the control register; the direction bit also overrides direction and drive enable.
// RULE19: Software keeps the direction bit low for correct writes.
// RULE20: Address strobe marks address cycles, data strobe marks data cycles.
// RULE21: Watchdog aborts a cycle whose host strobe lasts over 10 us.
// RULE22: A timeout is reported in status bit 0.
// RULE23: Software clears control bits 0, 1 and 3 before any cycle.
// RULE24: Wait and interrupt inputs are synchronised before use.
`timescale 1ns/10ps
`include "epp_consts.svh"
module epp_cycle_engine
    import epp_pkg::*;
#(
    parameter int TIMEOUT_CYC = `EPP_TIMEOUT_CYC,
    parameter int ADDR_W = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_ready,
    input wire logic [7:0] port_data_bus_in,
    output logic [7:0] port_data_bus_out,
    output logic port_data_drive_en,
    output logic n_write,
    output logic n_data_stb,
    output logic n_addr_stb,
    output logic n_periph_reset,
    output logic port_direction_out,
    input wire logic n_wait,
    input wire logic intr_in,
    output logic intr_out
);
    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("TIMEOUT_CYC must be at least 2");
    end
    if (ADDR_W < 3) begin : g_bad_addr_w
        $error("ADDR_W must be at least 3");
    end

    localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CNT_W-1:0] TIMEOUT_LIM = CNT_W'(TIMEOUT_CYC);

    // ----------------------------------------
    // Address decoding
    // ----------------------------------------
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [3:0] off);
        addr_is = (a == ADDR_W'(off));
    endfunction : addr_is

    wire logic sel_ctrl = addr_is(reg_addr, `EPP_REG_CTRL);
    wire logic sel_stat = addr_is(reg_addr, `EPP_REG_STATUS);
    wire logic sel_data = addr_is(reg_addr, `EPP_REG_DATA);
    wire logic sel_addr = addr_is(reg_addr, `EPP_REG_ADDR);
    wire logic sel_port = sel_data | sel_addr;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic wait_n_s;
    logic intr_s;
    logic [7:0] port_data_s;
    // RULE24 Sync wait input
    epp_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_wait (
        .clk(clk),
        .nrst(nrst),
        .d(n_wait),
        .q(wait_n_s)
    );
    // RULE24 Sync interrupt input
    epp_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_intr (
        .clk(clk),
        .nrst(nrst),
        .d(intr_in),
        .q(intr_s)
    );
    // Sync port data input
    epp_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_data (
        .clk(clk),
        .nrst(nrst),
        .d(port_data_bus_in),
        .q(port_data_s)
    );

    // ----------------------------------------
    // State and registers
    // ----------------------------------------
    epp_state_t state;
    epp_state_t next_state;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic timeout_flag;
    logic next_timeout_flag;
    logic intr_seen;
    logic intr_prev;
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] next_wd_cnt;
    logic cyc_read;
    logic cyc_addr;
    logic [7:0] next_rdata;
    logic [7:0] next_port_out;

    wire logic ctrl_dir = ctrl[`EPP_CTRL_DIR_BIT];
    wire logic in_cycle = (state == EPP_STROBE) || (state == EPP_HOLD);
    wire logic wd_expired = (wd_cnt >= TIMEOUT_LIM);

    // ----------------------------------------
    // Host cycle decoding
    // ----------------------------------------
    // A host cycle to a port register is one strobe; the engine runs the
    // peripheral handshake and answers once wait goes high or on timeout.
    wire logic port_wr = reg_wr && sel_port && (state == EPP_IDLE);
    wire logic port_rd = reg_rd && sel_port && (state == EPP_IDLE);
    // RULE12 Complete on wait high
    wire logic wait_done = wait_n_s;
    wire logic cyc_end = (state == EPP_HOLD) && (wait_done || wd_expired);

    // RULE4 Ready held low while waiting
    assign reg_ready = !(in_cycle || port_wr || port_rd);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            EPP_IDLE: begin
                if (port_wr || port_rd) begin
                    next_state = EPP_STROBE;
                end
            end
            EPP_STROBE: begin
                next_state = EPP_HOLD;
            end
            EPP_HOLD: begin
                // RULE21 Watchdog abort
                if (wd_expired && !wait_done) begin
                    next_state = EPP_ABORT;
                end else if (wait_done) begin
                    next_state = EPP_IDLE;
                end
            end
            EPP_ABORT: begin
                next_state = EPP_IDLE;
            end
            default: begin
                next_state = EPP_IDLE;
            end
        endcase
    end

    // RULE21 Watchdog counter
    assign next_wd_cnt = in_cycle ? (wd_expired ? wd_cnt : wd_cnt + CNT_W'(1)) : '0;

    // RULE22 Timeout status, set wins over clear
    wire logic to_set = (state == EPP_HOLD) && wd_expired && !wait_done;
    wire logic to_clr = reg_wr && sel_stat && reg_wdata[`EPP_STAT_TIMEOUT_BIT];
    assign next_timeout_flag = to_set | (timeout_flag & ~to_clr);

    assign next_ctrl = (reg_wr && sel_ctrl) ? reg_wdata : ctrl;

    // RULE5 Latch host byte for port bus
    assign next_port_out = port_wr ? reg_wdata : port_data_bus_out;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [7:0] stat_word;
    always_comb begin
        stat_word = 8'h00;
        stat_word[`EPP_STAT_TIMEOUT_BIT] = timeout_flag;
        stat_word[`EPP_STAT_INTR_BIT] = intr_s;
        stat_word[`EPP_STAT_BUSY_BIT] = in_cycle;
    end
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd && sel_ctrl) begin
            next_rdata = ctrl;
        end else if (reg_rd && sel_stat) begin
            next_rdata = stat_word;
        end else if (cyc_end && cyc_read) begin
            next_rdata = port_data_s;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= EPP_IDLE;
            ctrl <= `EPP_CTRL_RESET_VAL;
            timeout_flag <= 1'b0;
            wd_cnt <= '0;
            reg_rdata <= 8'h00;
            port_data_bus_out <= 8'h00;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            timeout_flag <= next_timeout_flag;
            wd_cnt <= next_wd_cnt;
            reg_rdata <= next_rdata;
            port_data_bus_out <= next_port_out;
        end
    end

    // RULE20 Capture cycle kind
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cyc_read <= 1'b0;
            cyc_addr <= 1'b0;
        end else if (port_wr || port_rd) begin
            cyc_read <= port_rd;
            cyc_addr <= sel_addr;
        end
    end

    // ----------------------------------------
    // Port outputs
    // ----------------------------------------
    // RULE3 Strobe during cycle
    // RULE9 Strobe drops at end
    wire logic stb_on = in_cycle;
    // RULE20 Address or data strobe
    assign n_addr_stb = !(stb_on && cyc_addr);
    assign n_data_stb = !(stb_on && !cyc_addr);
    // RULE17 Direction follows control bit or read
    wire logic dir_hi = ctrl_dir || (in_cycle && cyc_read);
    // RULE16 Direction encoding
    assign port_direction_out = dir_hi;
    // RULE2 Drive port bus on write
    // RULE7 Float bus during read
    // RULE11 Enable follows direction between cycles
    assign port_data_drive_en = !dir_hi;
    // RULE18 nwrite overridden by control bit 1 and by the direction bit
    assign n_write = dir_hi || ctrl[`EPP_CTRL_NWRITE_BIT];
    // RULE15 Peripheral reset output
    assign n_periph_reset = ctrl[`EPP_CTRL_RESET_BIT];

    // ----------------------------------------
    // Interrupt pass-through
    // ----------------------------------------
    // RULE14 Uninverted interrupt with edge note
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            intr_prev <= 1'b0;
            intr_seen <= 1'b0;
        end else begin
            intr_prev <= intr_s;
            intr_seen <= intr_s && !intr_prev;
        end
    end
    assign intr_out = intr_s | intr_seen;
endmodule : epp_cycle_engine

// file: tb/epp_engine_monitor.sv
// Concurrent checks on the cycle engine ports
`timescale 1ns/10ps
module epp_engine_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_ready,
    input wire logic port_data_drive_en,
    input wire logic n_write,
    input wire logic n_data_stb,
    input wire logic n_addr_stb,
    input wire logic n_periph_reset,
    input wire logic port_direction_out,
    input wire logic intr_in,
    input wire logic intr_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_drv; port_data_drive_en == !port_direction_out; endproperty
    a_drv: assert property (p_drv) else $error("drive enable wrong");
    property p_excl; n_data_stb || n_addr_stb; endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    property p_ready; !(n_data_stb && n_addr_stb) |-> !reg_ready; endproperty
    a_ready: assert property (p_ready) else $error("ready high in cycle");
    property p_wr; reg_wr && reg_addr == 4'h2 && n_data_stb && n_addr_stb
        && $past(n_data_stb && n_addr_stb) |=> !n_data_stb; endproperty
    a_wr: assert property (p_wr) else $error("no data strobe");
    property p_rd; reg_rd && reg_addr == 4'h3 && n_data_stb && n_addr_stb
        && $past(n_data_stb && n_addr_stb)
        |=> !n_addr_stb && port_direction_out && n_write && !port_data_drive_en; endproperty
    a_rd: assert property (p_rd) else $error("bad read strobe");
    property p_wdog; $fell(n_data_stb) |-> ##[1:40] n_data_stb; endproperty
    a_wdog: assert property (p_wdog) else $error("cycle not aborted");
    property p_prst; reg_wr && reg_addr == 4'h0
        |=> n_periph_reset == $past(reg_wdata[2]); endproperty
    a_prst: assert property (p_prst) else $error("reset out wrong");
    property p_ihi; intr_in [*6] |-> intr_out; endproperty
    a_ihi: assert property (p_ihi) else $error("intr not passed");
    property p_ilo; !intr_in [*6] |-> !intr_out; endproperty
    a_ilo: assert property (p_ilo) else $error("intr inverted");
endmodule : epp_engine_monitor
bind epp_cycle_engine epp_engine_monitor epp_engine_monitor_inst (
    .clk(clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_ready(reg_ready),
    .port_data_drive_en(port_data_drive_en),
    .n_write(n_write),
    .n_data_stb(n_data_stb),
    .n_addr_stb(n_addr_stb),
    .n_periph_reset(n_periph_reset),
    .port_direction_out(port_direction_out),
    .intr_in(intr_in),
    .intr_out(intr_out)
);

// file: tb/epp_periph_model.sv
// Behavioural parallel port peripheral
`timescale 1ns/10ps
module epp_periph_model (
    input wire logic clk,
    input wire logic n_data_stb,
    input wire logic n_addr_stb,
    input wire logic port_data_drive_en,
    input wire logic [7:0] port_data_bus_out,
    input wire logic [7:0] rd_byte,
    input wire logic [7:0] dly,
    output logic n_wait = 1'b0,
    output logic [7:0] port_data_bus_in
);
    logic [7:0] cnt = 8'h00;
    logic drv = 1'b0;
    logic [7:0] last = 8'h00;
    // data before wait, float after strobe
    always_ff @(posedge clk) begin
        cnt <= (n_data_stb && n_addr_stb) ? 8'h00 : cnt + 8'h01;
        drv <= !(n_data_stb && n_addr_stb) && cnt >= dly && !port_data_drive_en;
        n_wait <= !(n_data_stb && n_addr_stb) && cnt > dly;
        last <= port_data_bus_in;
    end
    assign port_data_bus_in = port_data_drive_en ? port_data_bus_out : (drv ? rd_byte : ~last);
endmodule : epp_periph_model

// file: tb/testbench.sv
// Self-checking bench for the cycle engine
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic intr_in = 1'b0;
    logic [7:0] rd_byte = 8'h00;
    logic [7:0] dly = 8'h00;
    wire logic [7:0] reg_rdata, port_data_bus_out, port_data_bus_in;
    wire logic reg_ready, port_data_drive_en, n_write, n_data_stb, n_addr_stb;
    wire logic n_periph_reset, port_direction_out, n_wait, intr_out;
    int bad_count = 0;
    int checks = 0;
    int seed = 88697;
    logic [7:0] exp_q[$];
    epp_cycle_engine #(.TIMEOUT_CYC(20)) epp_cycle_engine_inst (
        .clk(clk),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .reg_ready(reg_ready),
        .port_data_bus_in(port_data_bus_in),
        .port_data_bus_out(port_data_bus_out),
        .port_data_drive_en(port_data_drive_en),
        .n_write(n_write),
        .n_data_stb(n_data_stb),
        .n_addr_stb(n_addr_stb),
        .n_periph_reset(n_periph_reset),
        .port_direction_out(port_direction_out),
        .n_wait(n_wait),
        .intr_in(intr_in),
        .intr_out(intr_out)
    );
    epp_periph_model epp_periph_model_inst (
        .clk(clk),
        .n_data_stb(n_data_stb),
        .n_addr_stb(n_addr_stb),
        .port_data_drive_en(port_data_drive_en),
        .port_data_bus_out(port_data_bus_out),
        .rd_byte(rd_byte),
        .dly(dly),
        .n_wait(n_wait),
        .port_data_bus_in(port_data_bus_in)
    );
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic test_done;
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask : bus
    task automatic cyc(input logic rd, input logic [3:0] a, input logic tmo);
        logic [7:0] d;
        d = 8'($random(seed));
        exp_q.push_back(d);
        rd_byte <= d;
        dly <= tmo ? 8'hff : 8'({$random(seed)} % 5);
        bus(!rd, a, d);
        chk("addr_stb", 8'(n_addr_stb), 8'(a != 4'h3));
        chk("data_stb", 8'(n_data_stb), 8'(a != 4'h2));
        chk("dir", 8'(port_direction_out), 8'(rd));
        chk("nwrite", 8'(n_write), 8'(rd));
        chk("drive_en", 8'(port_data_drive_en), 8'(!rd));
        if (!rd) chk("pd_out", port_data_bus_out, exp_q[0]);
        for (int i = 0; i < 40 && reg_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("ready", 8'(reg_ready), 8'h01);
        chk("stb_end", 8'(n_data_stb & n_addr_stb), 8'h01);
        if (rd && !tmo) chk("rdata", reg_rdata, exp_q[0]);
        void'(exp_q.pop_front());
        @(posedge clk);
        #1;
        bus(1'b0, 4'h1, 8'h00);
        chk("timeout", 8'(reg_rdata[0]), 8'(tmo));
        bus(1'b1, 4'h1, 8'h01);
    endtask : cyc
    initial begin
        @(posedge clk);
        #1;
        chk("rst_stb", 8'(n_data_stb & n_addr_stb), 8'h01);
        chk("rst_dir", 8'(port_direction_out), 8'h00);
        chk("rst_nreset", 8'(n_periph_reset), 8'h01);
        @(posedge clk);
        nrst <= 1'b1;
        bus(1'b1, 4'h0, 8'h00);
        chk("nreset", 8'(n_periph_reset), 8'h00);
        bus(1'b1, 4'h0, 8'h24);
        chk("dir_bit", 8'(port_direction_out), 8'h01);
        bus(1'b1, 4'h0, 8'h06);
        chk("override", 8'(n_write), 8'h01);
        bus(1'b1, 4'h0, 8'h04);
        chk("dir_def", 8'(port_direction_out), 8'h00);
        bus(1'b1, 4'h4, 8'h5a);
        chk("unmapped", 8'(n_data_stb & n_addr_stb), 8'h01);
        for (int k = 0; k < 12; k++) begin
            cyc(k[0], {3'h1, k[1]}, k > 9);
        end
        @(posedge clk);
        intr_in <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk("intr_hi", 8'(intr_out), 8'h01);
        bus(1'b0, 4'h1, 8'h00);
        chk("intr_sync", 8'(reg_rdata[1]), 8'h01);
        @(posedge clk);
        intr_in <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("intr_lo", 8'(intr_out), 8'h00);
        test_done();
    end
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule : testbench
